//--- cqp_acc_seq.v
`timescale 1ns/1ns
`include "cqp_consts.vh"

module cqp_acc_seq (
    input  wire       pclk,              // Processor clock
    input  wire       presetn,           // Async reset, active low
    input  wire       start,             // Launch one access, pulse
    input  wire [2:0] acc_type,          // Access type code
    input  wire [1:0] acc_size,          // Size for load/store/atomic
    input  wire       freeze,            // Pipeline frozen, hold cycle
    output wire       busy,              // Sequence in progress
    output reg        read_not_write,    // 1 read, 0 write
    output reg  [1:0] transfer_size,     // Size of current address
    output reg        write_strobe_n,    // Store data on bus, low
    output reg        early_write,       // First store address cycle
    output reg        atomic_cycle_flag  // Atomic access cycles
);

    reg       active_q;
    reg [1:0] step_q;
    reg [2:0] type_q;
    reg [1:0] size_q;

    // Index of the last address cycle of a type
    function [1:0] last_step;
        input [2:0] t;
        case (t)
            `CQP_T_FETCH, `CQP_T_LOAD: last_step = 2'h0;
            `CQP_T_STORE, `CQP_T_FPST, `CQP_T_LDD: last_step = 2'h1;
            default: last_step = 2'h2;
        endcase
    endfunction

    // Types with store address cycles
    function is_store;
        input [2:0] t;
        is_store = (t == `CQP_T_STORE) || (t == `CQP_T_STD) ||
                   (t == `CQP_T_ATOM) || (t == `CQP_T_FPST) ||
                   (t == `CQP_T_FPSTD);
    endfunction

    assign busy = active_q;

    // Step through address cycles, stalled by freeze
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_q <= 1'b0;
            step_q   <= 2'h0;
            type_q   <= `CQP_T_FETCH;
            size_q   <= `CQP_SZ_WORD;
        end else if (!active_q) begin
            if (start) begin
                active_q <= 1'b1;
                step_q   <= 2'h0;
                type_q   <= acc_type;
                size_q   <= acc_size;
            end
        end else if (!freeze) begin
            if (step_q == last_step(type_q)) begin
                active_q <= 1'b0;
                step_q   <= 2'h0;
            end else begin
                step_q <= step_q + 2'h1;
            end
        end
    end

    // Unregistered qualifiers decoded from the current cycle
    always @* begin
        read_not_write    = 1'b1;
        transfer_size     = `CQP_SZ_WORD;
        write_strobe_n    = 1'b1;
        early_write       = 1'b0;
        atomic_cycle_flag = 1'b0;
        if (active_q) begin
            read_not_write = ~is_store(type_q) |
                ((type_q == `CQP_T_ATOM) && (step_q == 2'h0));
            case (type_q)
                `CQP_T_FETCH, `CQP_T_FPST:
                    transfer_size = `CQP_SZ_WORD;
                `CQP_T_LDD, `CQP_T_STD, `CQP_T_FPSTD:
                    transfer_size = `CQP_SZ_DBL;
                default:
                    transfer_size = size_q;
            endcase
            case (type_q)
                `CQP_T_STORE, `CQP_T_FPST: begin
                    early_write    = (step_q == 2'h0);
                    write_strobe_n = (step_q != 2'h1);
                end
                `CQP_T_STD, `CQP_T_FPSTD: begin
                    early_write    = (step_q == 2'h0);
                    write_strobe_n = (step_q == 2'h0);
                end
                `CQP_T_ATOM: begin
                    early_write       = (step_q == 2'h1);
                    write_strobe_n    = (step_q != 2'h2);
                    atomic_cycle_flag = 1'b1;
                end
                default: begin
                    early_write    = 1'b0;
                    write_strobe_n = 1'b1;
                end
            endcase
        end
    end

endmodule

//--- cqp_consts.vh
`ifndef CQP_CONSTS_VH
`define CQP_CONSTS_VH

// Register byte offsets on the APB port
`define CQP_OFF_ACC      12'h000
`define CQP_OFF_COP      12'h004
`define CQP_OFF_STAT     12'h008
`define CQP_OFF_TRAPS    12'h00c

// Access command fields
`define CQP_ACC_TYPE     2:0
`define CQP_ACC_SIZE     5:4

// Coprocessor command fields
`define CQP_COP_SLOT     0
`define CQP_COP_CLS      3:2
`define CQP_COP_MASK     7:4

// Status bit positions
`define CQP_ST_BUSY      0
`define CQP_ST_PEND      1
`define CQP_ST_FROZEN    2
`define CQP_ST_CCV       3
`define CQP_ST_CC        5:4
`define CQP_ST_EXC       6
`define CQP_ST_ACK       7
`define CQP_ST_TRAP      8
`define CQP_ST_BRDONE    9
`define CQP_ST_BRTAKEN   10

// Access types
`define CQP_T_FETCH      3'h0
`define CQP_T_LOAD       3'h1
`define CQP_T_STORE      3'h2
`define CQP_T_LDD        3'h3
`define CQP_T_STD        3'h4
`define CQP_T_ATOM       3'h5
`define CQP_T_FPST       3'h6
`define CQP_T_FPSTD      3'h7

// Transfer size codes
`define CQP_SZ_BYTE      2'h0
`define CQP_SZ_HALF      2'h1
`define CQP_SZ_WORD      2'h2
`define CQP_SZ_DBL       2'h3

// Coprocessor instruction classes
`define CQP_CLS_OP       2'h0
`define CQP_CLS_BR       2'h1
`define CQP_CLS_LS       2'h2

// Reset values
`define CQP_RST_ACC      32'h00000020
`define CQP_RST_COP      32'h00000000
`define CQP_RST_CCV      1'h1

`endif

//--- cqp_cop_model.sv
`timescale 1ns/1ns
module cqp_cop_model (
    input  wire       pclk,              // Clock
    input  wire       presetn,           // Reset, low
    input  wire [1:0] cc_set,            // Codes after compare
    input  wire       cmp_go,            // Start compare
    input  wire       hold_go,           // Want hold
    input  wire       exc_go,            // Raise exception
    input  wire       cop_exception_ack, // Trap taken
    output reg  [1:0] cop_cond_codes,    // Condition codes
    output reg        cop_cond_valid,    // Codes valid
    output reg        cop_exception,     // Exception
    output reg        cop_hold           // Hold
);
    reg [2:0] cnt_q;

    // Compare queue; codes churn while invalid
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cop_cond_codes <= 2'h0;
            cop_cond_valid <= 1'b1;
            cnt_q <= 3'h0;
        end else if (cmp_go) begin
            cop_cond_valid <= 1'b0;
            cnt_q <= 3'h4;
        end else if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
            cop_cond_valid <= (cnt_q == 3'h1);
            cop_cond_codes <= (cnt_q == 3'h1) ? cc_set : ~cop_cond_codes;
        end
    end

    // Exception kept until ack; hold released a cycle after it
    // Never signalled by memory strobes under hold
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cop_exception <= 1'b0;
            cop_hold <= 1'b0;
        end else begin
            if (exc_go)
                cop_exception <= 1'b1;
            else if (cop_exception_ack)
                cop_exception <= 1'b0;
            cop_hold <= hold_go & ~cop_exception;
        end
    end
endmodule

//--- cqp_in_reg.v
`timescale 1ns/1ns
`include "cqp_consts.vh"

module cqp_in_reg #(
    parameter         W   = 1,
    parameter [W-1:0] RST = {W{1'b0}}
) (
    input  wire         pclk,    // Processor clock
    input  wire         presetn, // Async reset, active low
    input  wire [W-1:0] d,       // Raw input from partner
    output reg  [W-1:0] q        // Registered copy
);

    // One register stage before any use
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= RST;
        end else begin
            q <= d;
        end
    end

endmodule

//--- cqp_top.v
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "cqp_consts.vh"

// Operation
// - read_not_write is 1 on reads, 0 only in store address cycles
// - Atomic access: read in load cycle, write in both store cycles
// - transfer_size: 00 byte, 01 half, 10 word, 11 doubleword word
// - Instruction fetches always show the word size code
// - Doubleword loads and stores show the double code every cycle
// - transfer_size describes only the address of the same cycle
// - transfer_size stays valid through all data address cycles
// - write_strobe_n low in the cycles carrying store data
// - early_write in first store cycle, or second atomic cycle
// - Coprocessor branch uses registered codes, valid with cop_cond_valid
// - Pipeline frozen while cop_cond_valid is low
// - Pending exception trap taken only at a later coprocessor insn
// - Registered cop_hold freezes the pipeline until released
// - Issue strobe for first or second buffer during decode
// - The two issue strobes are never high together
// - Registered acknowledge after trap, dropped after exception drops
module cqp_top (
    input  wire        pclk,              // Processor clock, 20 MHz
    input  wire        presetn,           // Async reset, active low
    input  wire        psel,              // APB select
    input  wire        penable,           // APB enable
    input  wire        pwrite,            // APB write direction
    input  wire [11:0] paddr,             // APB byte address
    input  wire [31:0] pwdata,            // APB write data
    output reg  [31:0] prdata,            // APB read data
    output wire        pready,            // APB ready, never waits
    output wire        pslverr,           // APB error, unmapped
    output wire        read_not_write,    // Access direction
    output wire [1:0]  transfer_size,     // Access size code
    output wire        write_strobe_n,    // Store data strobe, low
    output wire        early_write,       // Early write indication
    output wire        atomic_cycle_flag, // Atomic access cycles
    input  wire [1:0]  cop_cond_codes,    // Coprocessor condition codes
    input  wire        cop_cond_valid,    // Codes valid, high
    input  wire        cop_exception,     // Exception request, high
    input  wire        cop_hold,          // Coprocessor hold, high
    output wire        cop_issue_slot1,   // Issue from first buffer
    output wire        cop_issue_slot2,   // Issue from second buffer
    output reg         cop_exception_ack, // Trap taken acknowledge
    output wire        pipeline_frozen    // Pipeline freeze state
);

    // Registered partner inputs
    wire [1:0]  cc_q;
    wire        ccv_q;
    wire        exc_q;
    wire        hold_q;

    // Command and status registers
    reg  [31:0] acc_cmd_q;
    reg  [31:0] cop_cmd_q;
    reg         cop_pend_q;
    reg         trap_q;
    reg         trap_d;
    reg         br_done_q;
    reg         br_done_d;
    reg         br_taken_q;
    reg  [15:0] trap_cnt_q;

    // Bus decode
    wire        acc_busy;
    wire        apb_wr;
    wire        apb_rd_setup;
    wire        wr_acc;
    wire        wr_cop;
    wire        wr_stat;
    wire        acc_start;

    // Coprocessor decisions
    wire        decide;
    wire        take_trap;
    wire        issue;
    wire [31:0] status;

    // Known register offset check
    function mapped;
        input [11:0] a;
        mapped = (a == `CQP_OFF_ACC) || (a == `CQP_OFF_COP) ||
                 (a == `CQP_OFF_STAT) || (a == `CQP_OFF_TRAPS);
    endfunction

    // Register the partner inputs once before use
    cqp_in_reg #(
        .W   (2),
        .RST (2'h0)
    ) u_cc_reg (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (cop_cond_codes),
        .q       (cc_q)
    );

    cqp_in_reg #(
        .W   (1),
        .RST (`CQP_RST_CCV)
    ) u_ccv_reg (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (cop_cond_valid),
        .q       (ccv_q)
    );

    cqp_in_reg #(
        .W   (1),
        .RST (1'h0)
    ) u_exc_reg (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (cop_exception),
        .q       (exc_q)
    );

    cqp_in_reg #(
        .W   (1),
        .RST (1'h0)
    ) u_hold_reg (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (cop_hold),
        .q       (hold_q)
    );

    // Pipeline freeze from coprocessor hold and pending compare
    assign pipeline_frozen = hold_q | ~ccv_q;

    // APB phase decode; slave answers with no wait state
    assign pready       = 1'b1;
    assign apb_wr       = psel & penable & pwrite;
    assign apb_rd_setup = psel & ~penable & ~pwrite;
    assign pslverr      = psel & penable & ~mapped(paddr);
    assign wr_acc       = apb_wr & (paddr == `CQP_OFF_ACC);
    assign wr_cop       = apb_wr & (paddr == `CQP_OFF_COP);
    assign wr_stat      = apb_wr & (paddr == `CQP_OFF_STAT);

    // A new access is refused while one is in progress
    assign acc_start = wr_acc & ~acc_busy;

    // Memory access qualifier sequencer
    cqp_acc_seq u_seq (
        .pclk              (pclk),
        .presetn           (presetn),
        .start             (acc_start),
        .acc_type          (pwdata[`CQP_ACC_TYPE]),
        .acc_size          (pwdata[`CQP_ACC_SIZE]),
        .freeze            (pipeline_frozen),
        .busy              (acc_busy),
        .read_not_write    (read_not_write),
        .transfer_size     (transfer_size),
        .write_strobe_n    (write_strobe_n),
        .early_write       (early_write),
        .atomic_cycle_flag (atomic_cycle_flag)
    );

    // Decode stage of the pending coprocessor instruction
    assign decide    = cop_pend_q & ~pipeline_frozen;
    assign take_trap = decide & exc_q & ~cop_exception_ack;
    assign issue     = decide & ~exc_q & ~cop_exception_ack;

    // One buffer select bit keeps the strobes exclusive
    assign cop_issue_slot1 = issue & ~cop_cmd_q[`CQP_COP_SLOT];
    assign cop_issue_slot2 = issue & cop_cmd_q[`CQP_COP_SLOT];

    // Command registers; coprocessor command waits while pending
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_cmd_q  <= `CQP_RST_ACC;
            cop_cmd_q  <= `CQP_RST_COP;
            cop_pend_q <= 1'b0;
        end else begin
            if (acc_start) begin
                acc_cmd_q <= pwdata;
            end
            if (wr_cop && !cop_pend_q) begin
                cop_cmd_q  <= pwdata;
                cop_pend_q <= 1'b1;
            end else if (take_trap || issue) begin
                cop_pend_q <= 1'b0;
            end
        end
    end

    // Acknowledge held until the exception is dropped
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cop_exception_ack <= 1'b0;
        end else if (take_trap) begin
            cop_exception_ack <= 1'b1;
        end else if (cop_exception_ack && !exc_q) begin
            cop_exception_ack <= 1'b0;
        end
    end

    // Sticky flags; a new event wins over a clear
    always @* begin
        trap_d    = take_trap |
            (trap_q & ~(wr_stat & pwdata[`CQP_ST_TRAP]));
        br_done_d = (issue & (cop_cmd_q[`CQP_COP_CLS] == `CQP_CLS_BR)) |
            (br_done_q & ~(wr_stat & pwdata[`CQP_ST_BRDONE]));
    end

    // Branch outcome, trap flags and trap count
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trap_q     <= 1'b0;
            br_done_q  <= 1'b0;
            br_taken_q <= 1'b0;
            trap_cnt_q <= 16'h0000;
        end else begin
            trap_q    <= trap_d;
            br_done_q <= br_done_d;
            if (issue && cop_cmd_q[`CQP_COP_CLS] == `CQP_CLS_BR) begin
                br_taken_q <= cop_cmd_q[4 + cc_q];
            end
            if (take_trap) begin
                trap_cnt_q <= trap_cnt_q + 16'h0001;
            end
        end
    end

    // Status word gathered from live state
    assign status = {21'h000000, br_taken_q, br_done_q, trap_q,
                     cop_exception_ack, exc_q, cc_q, ccv_q,
                     pipeline_frozen, cop_pend_q, acc_busy};

    // Read data captured in the setup phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (apb_rd_setup) begin
            case (paddr)
                `CQP_OFF_ACC:   prdata <= acc_cmd_q;
                `CQP_OFF_COP:   prdata <= cop_cmd_q;
                `CQP_OFF_STAT:  prdata <= status;
                `CQP_OFF_TRAPS: prdata <= {16'h0000, trap_cnt_q};
                default:        prdata <= 32'h00000000;
            endcase
        end
    end

endmodule

//--- cqp_top_chk_props.sv
`timescale 1ns/1ns
module cqp_top_chk (
    input wire       pclk,              // Clock
    input wire       presetn,           // Reset, low
    input wire       psel,              // Select
    input wire       penable,           // Enable
    input wire       pwrite,            // Direction
    input wire       read_not_write,    // Direction out
    input wire [1:0] transfer_size,     // Size code
    input wire       write_strobe_n,    // Data strobe
    input wire       early_write,       // Early write
    input wire       atomic_cycle_flag, // Atomic
    input wire       cop_cond_valid,    // Codes valid
    input wire       cop_exception,     // Exception
    input wire       cop_hold,          // Hold
    input wire       cop_issue_slot1,   // Issue 1
    input wire       cop_issue_slot2,   // Issue 2
    input wire       cop_exception_ack, // Acknowledge
    input wire       pipeline_frozen    // Freeze
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Access qualifier sequencing
    property p_early_we;
        early_write && !pipeline_frozen |=> !write_strobe_n;
    endproperty
    a_early_we: assert property (p_early_we)
        else $error("no strobe after early write");
    property p_atom;
        $rose(atomic_cycle_flag) && !pipeline_frozen |-> read_not_write
            ##1 !read_not_write && early_write && atomic_cycle_flag;
    endproperty
    a_atom: assert property (p_atom)
        else $error("atomic order wrong");
    property p_we_size;
        $fell(write_strobe_n) |-> $stable(transfer_size);
    endproperty
    a_we_size: assert property (p_we_size)
        else $error("size moved at store data");
    property p_frozen_stable;
        $past(pipeline_frozen && !(psel && penable && pwrite)) |->
            $stable({read_not_write, transfer_size, write_strobe_n,
                     early_write});
    endproperty
    a_frozen_stable: assert property (p_frozen_stable)
        else $error("qualifiers moved while frozen");

    // Coprocessor handshakes
    property p_slot_excl;
        !(cop_issue_slot1 && cop_issue_slot2);
    endproperty
    a_slot_excl: assert property (p_slot_excl)
        else $error("both issue strobes high");
    property p_hold_freeze;
        cop_hold |=> pipeline_frozen;
    endproperty
    a_hold_freeze: assert property (p_hold_freeze)
        else $error("hold did not freeze");
    property p_valid_freeze;
        !cop_cond_valid |=> pipeline_frozen;
    endproperty
    a_valid_freeze: assert property (p_valid_freeze)
        else $error("invalid codes did not freeze");
    property p_frozen_noissue;
        pipeline_frozen |-> !cop_issue_slot1 && !cop_issue_slot2;
    endproperty
    a_frozen_noissue: assert property (p_frozen_noissue)
        else $error("issue while frozen");
    property p_ack_rise;
        $rose(cop_exception_ack) |-> $past(cop_exception, 2);
    endproperty
    a_ack_rise: assert property (p_ack_rise)
        else $error("ack without exception");
    property p_ack_drop;
        cop_exception_ack && !cop_exception |-> ##2 !cop_exception_ack;
    endproperty
    a_ack_drop: assert property (p_ack_drop)
        else $error("ack not dropped");
endmodule

//--- test_cpu_bus_qualifiers_and_cop_port.sv
`timescale 1ns/1ns
`include "cqp_consts.vh"
module test_cpu_bus_qualifiers_and_cop_port;
    reg         pclk, presetn, psel, penable, pwrite;
    reg  [11:0] paddr;
    reg  [31:0] pwdata, rd_q;
    reg  [1:0]  cc_set;
    reg         cmp_go, hold_go, exc_go, err_q;
    reg  [5:0]  e_q, qual_q;
    wire [31:0] prdata;
    wire [1:0]  transfer_size, cop_cond_codes;
    wire        pready, pslverr, read_not_write, write_strobe_n;
    wire        early_write, atomic_cycle_flag, cop_cond_valid;
    wire        cop_exception, cop_hold, cop_issue_slot1, cop_issue_slot2;
    wire        cop_exception_ack, pipeline_frozen;
    wire [5:0]  qual_w = {read_not_write, early_write, write_strobe_n,
                          atomic_cycle_flag, transfer_size};
    integer     bad_count, cmp_count, i, k;
    // Size field sent with each access type, type 7 first
    localparam [15:0] SZF = {2'h1, 2'h2, 2'h1, 2'h0, 2'h1, 2'h1, 2'h0, 2'h1};

    cqp_top cqp_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .read_not_write, .transfer_size,
        .write_strobe_n, .early_write, .atomic_cycle_flag, .cop_cond_codes,
        .cop_cond_valid, .cop_exception, .cop_hold, .cop_issue_slot1,
        .cop_issue_slot2, .cop_exception_ack, .pipeline_frozen);
    cqp_cop_model cqp_cop_model_i (.pclk, .presetn, .cc_set, .cmp_go,
        .hold_go, .exc_go, .cop_exception_ack, .cop_cond_codes,
        .cop_cond_valid, .cop_exception, .cop_hold);

    // Memory side copy of the unregistered qualifiers, taken at each rising edge
    always @(posedge pclk) qual_q <= qual_w;

    // Clock
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task check(input [31:0] seen, input [31:0] want);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== want) begin
                bad_count = bad_count + 1;
                $display("BAD %0t seen %h want %h", $time, seen, want);
            end
        end
    endtask

    // One transfer, entered at a rising edge
    task apb(input w, input [11:0] a, input [31:0] d);
        integer n;
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            @(posedge pclk);
            while (pready !== 1'b1 && n < 20) begin
                n = n + 1;
                @(posedge pclk);
            end
            if (pready !== 1'b1)
                bad_count = bad_count + 1;
            rd_q = prdata;
            err_q = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    // Expected {rnw, early, we_n, atomic, size} c cycles after launch
    function [5:0] exq(input [2:0] t, input integer c);
        reg [3:0] q;
        reg [1:0] s;
        integer   n;
        begin
            n = (t < 2) ? 1 : (t == 4 || t == 5 || t == 7) ? 3 : 2;
            s = (t == 0) ? 2'h2 : SZF[t*2 +: 2];
            if (t == 3 || t == 4 || t == 7)
                s = 2'h3;
            case (t)
                2, 4, 6, 7: q = (c == 1) ? 4'b0110 : 4'b0000;
                5: q = (c == 1) ? 4'b1011 : (c == 2) ? 4'b0111 : 4'b0001;
                default: q = 4'b1010;
            endcase
            exq = (c > n) ? 6'b101010 : {q, s};
        end
    endfunction

    task end_of_test;
        begin
            $display("compares %0d mismatches %0d", cmp_count, bad_count);
            if (bad_count == 0 && cmp_count > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask

    // Hang guard
    initial begin
        #400000;
        bad_count = bad_count + 1;
        end_of_test;
    end

    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, cmp_go, hold_go, exc_go} = 7'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        cc_set = 2'h0;
        bad_count = 0;
        cmp_count = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `CQP_OFF_ACC, 32'h0);
        check(rd_q, `CQP_RST_ACC);
        @(posedge pclk);
        apb(1'b0, 12'h010, 32'h0);
        check(err_q, 1'b1);
        check(rd_q, 32'h0);
        // Every access type, cycle by cycle
        for (i = 0; i < 8; i = i + 1) begin
            apb(1'b1, `CQP_OFF_ACC, {26'h0, SZF[i*2 +: 2], 1'b0, i[2:0]});
            for (k = 1; k < 5; k = k + 1) begin
                #1;
                e_q = exq(i[2:0], k);
                check(qual_w[5:2], e_q[5:2]);
                check(qual_w[1:0], e_q[1:0]);
                if (k > 1)
                    check(qual_q, exq(i[2:0], k - 1));
                @(posedge pclk);
            end
        end
        // Issue strobes from both buffers
        for (i = 0; i < 2; i = i + 1) begin
            apb(1'b1, `CQP_OFF_COP, i);
            #1;
            check({cop_issue_slot2, cop_issue_slot1}, i + 1);
            @(posedge pclk);
        end
        // Branch on each code value after a compare
        for (i = 0; i < 4; i = i + 1) begin
            cc_set <= i[1:0];
            cmp_go <= 1'b1;
            @(posedge pclk);
            cmp_go <= 1'b0;
            repeat (3) @(posedge pclk);
            #1;
            check(pipeline_frozen, 1'b1);
            repeat (5) @(posedge pclk);
            apb(1'b1, `CQP_OFF_COP, 32'h54);
            repeat (2) @(posedge pclk);
            apb(1'b0, `CQP_OFF_STAT, 32'h0);
            check(rd_q[10:9], {~i[0], 1'b1});
            check(rd_q[5:4], i[1:0]);
        end
        // Hold defers a pending issue until released
        hold_go <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(1'b1, `CQP_OFF_COP, 32'h0);
        #1;
        check(pipeline_frozen, 1'b1);
        check(cop_issue_slot1, 1'b0);
        @(posedge pclk);
        hold_go <= 1'b0;
        k = 0;
        while (cop_issue_slot1 !== 1'b1 && k < 8) begin
            @(posedge pclk);
            #1;
            k = k + 1;
        end
        check(k, 2);
        @(posedge pclk);
        // Exception raised under hold, trap at next command
        // Exception comes only on its own line, no memory strobe
        hold_go <= 1'b1;
        repeat (3) @(posedge pclk);
        exc_go <= 1'b1;
        @(posedge pclk);
        exc_go <= 1'b0;
        hold_go <= 1'b0;
        repeat (4) @(posedge pclk);
        #1;
        check(cop_exception_ack, 1'b0);
        @(posedge pclk);
        apb(1'b1, `CQP_OFF_COP, 32'h8);
        #1;
        check({cop_issue_slot2, cop_issue_slot1}, 2'h0);
        @(posedge pclk);
        #1;
        check(cop_exception_ack, 1'b1);
        k = 0;
        while (cop_exception_ack !== 1'b0 && k < 8) begin
            @(posedge pclk);
            #1;
            k = k + 1;
        end
        check({cop_exception, cop_exception_ack}, 2'h0);
        @(posedge pclk);
        apb(1'b0, `CQP_OFF_TRAPS, 32'h0);
        check(rd_q, 32'h1);
        end_of_test;
    end
endmodule

bind cqp_top cqp_top_chk cqp_top_chk_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .read_not_write, .transfer_size, .write_strobe_n, .early_write,
    .atomic_cycle_flag, .cop_cond_valid, .cop_exception, .cop_hold,
    .cop_issue_slot1, .cop_issue_slot2, .cop_exception_ack, .pipeline_frozen);
